// File: core/conv_pkg.sv
`default_nettype none

package conv_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] SEL_ADDR    = 8'h08;
   localparam logic [7:0] ACTIVE_ADDR = 8'h0C;
   localparam logic [7:0] RESULT_ADDR = 8'h10;

   // control register fields
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_START_BIT = 1;
   localparam int CTRL_AUTO_BIT  = 2;
   localparam int CTRL_FREE_BIT  = 3;
   localparam int CTRL_DIV_LSB   = 4;
   localparam int DIV_W          = 3;

   // status register fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   localparam int STAT_VALID_BIT = 2;
   localparam int STAT_HALF_BIT  = 3;
   localparam int STAT_DIFF_BIT  = 4;

   // selection register fields
   localparam int SEL_CHAN_LSB = 0;
   localparam int SEL_REF_LSB  = 6;
   localparam int REF_W        = 2;

   // reset values
   localparam logic [DIV_W-1:0] DIV_RESET  = 3'h0;
   localparam logic [7:0]       SEL_RESET  = 8'h00;
   localparam logic [9:0]       RESULT_RST = 10'h000;

   // conversion lengths in converter clock cycles
   localparam logic [4:0] LEN_NORMAL = 5'h0D;
   localparam logic [4:0] LEN_SYNC   = 5'h0E;
   localparam logic [4:0] LEN_FIRST  = 5'h19;

   // sample-and-hold converter clock index within each kind
   localparam logic [4:0] SH_NORMAL = 5'h01;
   localparam logic [4:0] SH_SYNC   = 5'h02;
   localparam logic [4:0] SH_FIRST  = 5'h0D;

   localparam logic [9:0] FULL_SCALE = 10'h3FF;

   typedef enum logic [1:0] {
      REF_EXTERNAL = 2'h0,
      REF_SUPPLY   = 2'h1,
      REF_UNUSED   = 2'h2,
      REF_INTERNAL = 2'h3
   } ref_source_type;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_PEND,
      CONV_RUN
   } conv_state_type;

endpackage : conv_pkg

`default_nettype wire

// File: core/conv_prescaler.sv
`default_nettype none

module conv_prescaler #(
   parameter int CNT_W = 7
) (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // control
   input  wire logic                      clear_i,
   input  wire logic [conv_pkg::DIV_W-1:0] div_sel_i,
   // converter clock strobe
   output logic                           tick_o
);
   import conv_pkg::*;

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] mask;

   if (CNT_W < 7) begin : g_bad_width
      $error("prescaler counter too narrow for divide by 128");
   end

   // divide select 0 and 1 both give divide by two
   always_comb begin
      mask = '1;
      if (div_sel_i == '0) begin
         mask = CNT_W'(1);
      end else begin
         mask = CNT_W'((1 << div_sel_i) - 1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + CNT_W'(1);
      end
   end

   assign tick_o = !clear_i && ((count_q & mask) == mask);

endmodule : conv_prescaler

`default_nettype wire

// File: core/conv_timing_select.sv
`default_nettype none

module conv_timing_select #(
   parameter int CHAN_W    = 5,
   parameter int DIFF_BASE = 8
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [7:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic                   ack_o,
   output logic [31:0]            dat_o,
   // trigger and analog side
   input  wire logic              trigger_i,
   input  wire logic [9:0]        sar_code_i,
   input  wire logic              over_range_i,
   // active selection and conversion events
   output logic [CHAN_W-1:0]      active_chan_o,
   output conv_pkg::ref_source_type active_ref_o,
   output logic                   ref_supply_o,
   output logic                   ref_internal_o,
   output logic                   ref_external_o,
   output logic                   conv_tick_o,
   output logic                   half_clk_o,
   output logic                   sample_hold_o,
   output logic                   conv_done_o,
   output logic                   busy_o
);
   import conv_pkg::*;

   if (CHAN_W < 1 || CHAN_W > 6 || DIFF_BASE >= (1 << CHAN_W)) begin : g_bad_param
      $error("channel width or differential base out of range");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic                 enable_q;
   logic                 start_q;
   logic                 auto_q;
   logic                 free_q;
   logic [DIV_W-1:0]     div_q;
   logic                 done_q;
   logic                 valid_q;
   logic [CHAN_W-1:0]    buf_chan_q;
   logic [REF_W-1:0]     buf_ref_q;
   logic [CHAN_W-1:0]    act_chan_q;
   logic [REF_W-1:0]     act_ref_q;
   logic [9:0]           result_q;
   logic                 first_q;
   logic                 half_q;
   logic                 trig_prev_q;
   logic                 trig_run_q;
   logic                 sh_q;
   logic                 done_pulse_q;
   conv_state_type       state_q;
   logic [4:0]           cnt_q;
   logic [4:0]           len_q;
   logic [4:0]           sh_idx_q;
   logic                 ack_q;
   logic [31:0]          dat_q;

   logic                 tick;
   logic                 wr_en;
   logic                 wr_ctrl;
   logic                 wr_stat;
   logic                 wr_sel;
   logic                 trig_edge;
   logic                 trig_start;
   logic                 user_start;
   logic                 last_cycle;
   logic                 finish;
   logic                 restart;
   logic                 begin_conv;
   logic                 update_ok;
   logic                 buf_diff;
   logic                 presc_clear;
   logic [31:0]          rd_word;

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   // ack is registered, so every access takes two cycles; writes land on the ack edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cyc_i && stb_i && !ack_q;
      end
   end

   assign wr_en   = cyc_i && stb_i && we_i && ack_q && sel_i[0];
   assign wr_ctrl = wr_en && (adr_i == CTRL_ADDR);
   assign wr_stat = wr_en && (adr_i == STATUS_ADDR);
   assign wr_sel  = wr_en && (adr_i == SEL_ADDR);

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (adr_i)
         CTRL_ADDR: begin
            rd_word[CTRL_EN_BIT]                        = enable_q;
            rd_word[CTRL_START_BIT]                     = start_q;
            rd_word[CTRL_AUTO_BIT]                      = auto_q;
            rd_word[CTRL_FREE_BIT]                      = free_q;
            rd_word[CTRL_DIV_LSB +: DIV_W]              = div_q;
         end
         STATUS_ADDR: begin
            rd_word[STAT_BUSY_BIT]                      = (state_q == CONV_RUN);
            rd_word[STAT_DONE_BIT]                      = done_q;
            rd_word[STAT_VALID_BIT]                     = valid_q;
            rd_word[STAT_HALF_BIT]                      = half_q;
            rd_word[STAT_DIFF_BIT]                      = (act_chan_q >= CHAN_W'(DIFF_BASE));
         end
         SEL_ADDR: begin
            rd_word[SEL_CHAN_LSB +: CHAN_W]             = buf_chan_q;
            rd_word[SEL_REF_LSB +: REF_W]               = buf_ref_q;
         end
         ACTIVE_ADDR: begin
            rd_word[SEL_CHAN_LSB +: CHAN_W]             = act_chan_q;
            rd_word[SEL_REF_LSB +: REF_W]               = act_ref_q;
         end
         RESULT_ADDR: begin
            rd_word[9:0]                                = result_q;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_q) begin
         dat_q <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // prescaler and half-rate clock
   // ----------------------------------------------------------------
   assign trig_edge  = trigger_i && !trig_prev_q;
   // edges while a conversion runs or waits are dropped
   assign trig_start = enable_q && auto_q && !free_q && trig_edge && (state_q == CONV_IDLE);
   // held clear while disabled, and restarted by a trigger
   assign presc_clear = !enable_q || trig_start;

   conv_prescaler #(
      .CNT_W     (7)
   ) u_prescaler (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (presc_clear),
      .div_sel_i (div_q),
      .tick_o    (tick)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= trigger_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || presc_clear) begin
         half_q <= 1'b0;
      end else if (tick) begin
         half_q <= !half_q;
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_q <= 1'b0;
         auto_q   <= 1'b0;
         free_q   <= 1'b0;
         div_q    <= DIV_RESET;
      end else if (wr_ctrl) begin
         enable_q <= dat_i[CTRL_EN_BIT];
         auto_q   <= dat_i[CTRL_AUTO_BIT];
         free_q   <= dat_i[CTRL_FREE_BIT];
         div_q    <= dat_i[CTRL_DIV_LSB +: DIV_W];
      end
   end

   // start bit stays high across free running restarts
   assign user_start = wr_ctrl && dat_i[CTRL_START_BIT] && dat_i[CTRL_EN_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_q) begin
         start_q <= 1'b0;
      end else if (user_start || trig_start) begin
         start_q <= 1'b1;
      end else if (finish && !restart) begin
         start_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   assign buf_diff   = (buf_chan_q >= CHAN_W'(DIFF_BASE));
   assign last_cycle = (state_q == CONV_RUN) && (cnt_q == len_q - 5'h01);
   assign finish     = tick && last_cycle;
   assign restart    = finish && auto_q && free_q && enable_q;
   assign begin_conv = tick && (state_q == CONV_PEND);

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_q) begin
         state_q <= CONV_IDLE;
      end else begin
         unique case (state_q)
            CONV_IDLE: begin
               if (user_start || trig_start) begin
                  state_q <= CONV_PEND;
               end
            end
            CONV_PEND: begin
               if (begin_conv) begin
                  state_q <= CONV_RUN;
               end
            end
            CONV_RUN: begin
               if (finish && !restart) begin
                  state_q <= CONV_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_q) begin
         first_q <= 1'b1;
      end else if (begin_conv) begin
         first_q <= 1'b0;
      end
   end

   // length and sample point are fixed when the conversion begins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q    <= 5'h00;
         len_q    <= LEN_NORMAL;
         sh_idx_q <= SH_NORMAL;
      end else if (begin_conv) begin
         cnt_q <= 5'h00;
         if (first_q) begin
            len_q    <= LEN_FIRST;
            sh_idx_q <= SH_FIRST;
         end else if (buf_diff && half_q) begin
            len_q    <= LEN_SYNC;
            sh_idx_q <= SH_SYNC;
         end else begin
            len_q    <= LEN_NORMAL;
            sh_idx_q <= SH_NORMAL;
         end
      end else if (restart) begin
         cnt_q    <= 5'h00;
         len_q    <= buf_diff ? LEN_SYNC : LEN_NORMAL;
         sh_idx_q <= buf_diff ? SH_SYNC : SH_NORMAL;
      end else if (tick && (state_q == CONV_RUN)) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_q         <= 1'b0;
         done_pulse_q <= 1'b0;
      end else begin
         sh_q         <= tick && (state_q == CONV_RUN) && (cnt_q == sh_idx_q);
         done_pulse_q <= finish;
      end
   end

   // triggered differential conversions that are not extended cannot settle;
   // the source is latched with the request, since the begin tick cannot tell who asked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_run_q <= 1'b0;
      end else if (trig_start || user_start) begin
         trig_run_q <= trig_start && !first_q && buf_diff;
      end
   end

   // ----------------------------------------------------------------
   // done flag and result
   // ----------------------------------------------------------------
   // a finishing conversion wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
      end else if (finish) begin
         done_q <= 1'b1;
      end else if (wr_stat && dat_i[STAT_DONE_BIT]) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= RESULT_RST;
         valid_q  <= 1'b0;
      end else if (finish) begin
         result_q <= over_range_i ? FULL_SCALE : sar_code_i;
         valid_q  <= !trig_run_q;
      end
   end

   // ----------------------------------------------------------------
   // selection buffer and frozen selection
   // ----------------------------------------------------------------
   // the buffer is always writable; only the frozen copy steers the analog mux
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_chan_q <= SEL_RESET[SEL_CHAN_LSB +: CHAN_W];
         buf_ref_q  <= SEL_RESET[SEL_REF_LSB +: REF_W];
      end else if (wr_sel) begin
         buf_chan_q <= dat_i[SEL_CHAN_LSB +: CHAN_W];
         buf_ref_q  <= dat_i[SEL_REF_LSB +: REF_W];
      end
   end

   // the finishing tick also reloads the frozen copy, so a restart on that
   // tick already converts the newly buffered channel
   assign update_ok = (state_q != CONV_RUN) || last_cycle;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_chan_q <= SEL_RESET[SEL_CHAN_LSB +: CHAN_W];
         act_ref_q  <= SEL_RESET[SEL_REF_LSB +: REF_W];
      end else if (tick && update_ok) begin
         act_chan_q <= buf_chan_q;
         act_ref_q  <= buf_ref_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign ack_o          = ack_q;
   assign dat_o          = dat_q;
   assign active_chan_o  = act_chan_q;
   assign active_ref_o   = ref_source_type'(act_ref_q);
   assign ref_supply_o   = (act_ref_q == REF_SUPPLY);
   assign ref_internal_o = (act_ref_q == REF_INTERNAL);
   assign ref_external_o = (act_ref_q == REF_EXTERNAL) || (act_ref_q == REF_UNUSED);
   assign conv_tick_o    = tick;
   assign half_clk_o     = half_q;
   assign sample_hold_o  = sh_q;
   assign conv_done_o    = done_pulse_q;
   assign busy_o         = start_q;

endmodule : conv_timing_select

`default_nettype wire

// File: tb/conv_timing_select_props.sv
`default_nettype none

module conv_timing_select_props #(
   parameter int CHAN_W = 5
) (
   // clock and reset
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   // bus
   input wire logic                    cyc_i,
   input wire logic                    stb_i,
   input wire logic                    ack_o,
   // converter side
   input wire logic [CHAN_W-1:0]       active_chan_o,
   input wire conv_pkg::ref_source_type active_ref_o,
   input wire logic                    ref_supply_o,
   input wire logic                    ref_internal_o,
   input wire logic                    ref_external_o,
   input wire logic                    conv_tick_o,
   input wire logic                    half_clk_o,
   input wire logic                    sample_hold_o,
   input wire logic                    conv_done_o,
   input wire logic                    busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import conv_pkg::*;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   ack_answer_a: assert property ($rose(cyc_i && stb_i) |=> ack_o ##1 !ack_o)
      else $error("ack not one cycle after request");

   // ----------------------------------------
   // selection and timing
   // ----------------------------------------
   ref_decode_a: assert property (ref_supply_o == (active_ref_o == REF_SUPPLY)
      && ref_internal_o == (active_ref_o == REF_INTERNAL)
      && ref_external_o == (active_ref_o == REF_EXTERNAL || active_ref_o == REF_UNUSED))
      else $error("reference decode wrong");
   sel_hold_a: assert property (!conv_tick_o |=> $stable(active_chan_o) && $stable(active_ref_o))
      else $error("active selection moved without a tick");
   tick_gap_a: assert property (conv_tick_o |=> !conv_tick_o)
      else $error("converter ticks back to back");
   half_toggle_a: assert property (conv_tick_o && busy_o && !ack_o |=> half_clk_o != $past(half_clk_o))
      else $error("half clock did not toggle on tick");
   hold_point_a: assert property (sample_hold_o |-> $past(conv_tick_o) && $past(busy_o))
      else $error("sample pulse outside a converting tick");
   done_pulse_a: assert property (conv_done_o |-> $past(conv_tick_o) && $past(busy_o) ##1 !conv_done_o)
      else $error("done pulse malformed");
   busy_clear_a: assert property ($fell(busy_o) && !$past(ack_o, 2) |-> conv_done_o)
      else $error("start bit cleared without completion");

   done_high_c: cover property (conv_done_o && half_clk_o);

endmodule : conv_timing_select_props

bind conv_timing_select conv_timing_select_props #(.CHAN_W(CHAN_W)) props (.clk_i, .rst_i, .cyc_i, .stb_i,
   .ack_o, .active_chan_o, .active_ref_o, .ref_supply_o, .ref_internal_o, .ref_external_o, .conv_tick_o,
   .half_clk_o, .sample_hold_o, .conv_done_o, .busy_o);

`default_nettype wire

// File: tb/tb.sv
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import conv_pkg::*;

   logic           clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, trigger_i, over_range_i;
   logic [7:0]     adr_i;
   logic [31:0]    dat_i, dat_o, rd;
   logic [9:0]     sar_code_i;
   logic [4:0]     active_chan_o;
   ref_source_type active_ref_o;
   logic           ref_supply_o, ref_internal_o, ref_external_o;
   logic           conv_tick_o, half_clk_o, sample_hold_o, conv_done_o, busy_o, h;
   int             n_fail, n_compared, t, s;
   // gain stage settling after a new differential channel, 125 us at 50 MHz
   localparam int  SETTLE_CYC = 6250;

   conv_timing_select dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .ack_o,
      .dat_o, .trigger_i, .sar_code_i, .over_range_i, .active_chan_o, .active_ref_o, .ref_supply_o,
      .ref_internal_o, .ref_external_o, .conv_tick_o, .half_clk_o, .sample_hold_o, .conv_done_o, .busy_o);

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // waits an edge first so cyc stays low for a cycle between accesses
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) n_fail++;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb

   // counts converting ticks up to the done pulse; a start from idle spends its first tick
   // leaving the pending state, so that tick only yields h, the half clock it saw;
   // s is the tick count at which the sample pulse shows
   task automatic run_conv(input logic from_idle);
      int   n;
      logic skip;
      skip = from_idle;
      t = 0;
      s = 0;
      h = 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (sample_hold_o === 1'b1) s = t;
         if (conv_tick_o === 1'b1 && busy_o === 1'b1) begin
            if (skip) begin
               h    = half_clk_o;
               skip = 1'b0;
            end else begin
               t++;
            end
         end
      end while (conv_done_o !== 1'b1 && n < 3000);
      if (n >= 3000) n_fail++;
   endtask : run_conv

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      @(posedge clk_i);
      check("busy", 0, busy_o);
      wb(0, ACTIVE_ADDR, 0);
      check("active", {24'h0, SEL_RESET}, rd);
      wb(0, 8'h20, 32'h0);
      check("unmapped", 0, rd);
   endtask : t_reset

   task automatic t_select();
      logic [2:0] ref_exp [4] = '{3'b001, 3'b100, 3'b001, 3'b010};
      wb(1, CTRL_ADDR, 32'h1);
      for (int r = 0; r < 4; r++) begin
         // nothing drives the external pin here, so every reference code is safe
         wb(1, SEL_ADDR, 32'((r << 6) | 3));
         wb(0, SEL_ADDR, 32'h0);
         check("sel readback", 32'((r << 6) | 3), rd);
         repeat (4) @(posedge clk_i);
         check("idle chan", 3, active_chan_o);
         check("ref lines", ref_exp[r], {ref_supply_o, ref_internal_o, ref_external_o});
      end
      wb(1, SEL_ADDR, 32'h43);
   endtask : t_select

   task automatic t_single();
      wb(1, CTRL_ADDR, 32'h0);
      wb(1, CTRL_ADDR, 32'h2);
      repeat (4) @(posedge clk_i);
      check("start while off", 0, busy_o);
      wb(1, CTRL_ADDR, 32'h1);
      sar_code_i <= 10'h155;
      wb(1, CTRL_ADDR, 32'h3);
      run_conv(1'b1);
      check("first length", 25, t);
      check("first sample", SH_FIRST + 1, s);
      @(posedge clk_i);
      check("start cleared", 0, busy_o);
      wb(0, RESULT_ADDR, 32'h0);
      check("result", 32'h155, rd);
      wb(1, CTRL_ADDR, 32'h3);
      wb(1, SEL_ADDR, 32'h45);
      wb(0, CTRL_ADDR, 32'h0);
      check("start bit busy", 1, rd[CTRL_START_BIT]);
      check("frozen chan", 3, active_chan_o);
      run_conv(1'b0);
      check("reloaded chan", 5, active_chan_o);
      over_range_i <= 1'b1;
      wb(1, CTRL_ADDR, 32'h23);
      run_conv(1'b1);
      check("single length", 13, t);
      wb(0, RESULT_ADDR, 32'h0);
      check("over range", 32'h3FF, rd);
      over_range_i <= 1'b0;
   endtask : t_single

   task automatic t_diff();
      wb(1, SEL_ADDR, 32'h48);
      repeat (SETTLE_CYC) @(posedge clk_i);
      for (int off = 0; off < 4; off++) begin
         repeat (off) @(posedge clk_i);
         wb(1, CTRL_ADDR, 32'h3);
         run_conv(1'b1);
         check("diff length", h ? 14 : 13, t);
         check("diff sample", h ? SH_SYNC + 1 : SH_NORMAL + 1, s);
      end
   endtask : t_diff

   task automatic t_free();
      wb(1, CTRL_ADDR, 32'hF);
      run_conv(1'b1);
      run_conv(1'b0);
      check("free length", 14, t);
      check("free sample", SH_SYNC + 1, s);
      wb(1, SEL_ADDR, 32'h49);
      check("old chan kept", 8, active_chan_o);
      run_conv(1'b0);
      check("new chan next", 9, active_chan_o);
      wb(1, CTRL_ADDR, 32'h0);
   endtask : t_free

   task automatic t_auto();
      wb(1, SEL_ADDR, 32'h48);
      wb(1, CTRL_ADDR, 32'h5);
      trigger_i <= 1'b1;
      run_conv(1'b1);
      check("trig first length", 25, t);
      trigger_i <= 1'b0;
      wb(0, STATUS_ADDR, 32'h0);
      check("extended valid", 1, rd[STAT_VALID_BIT]);
      trigger_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      trigger_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      trigger_i <= 1'b1;
      run_conv(1'b0);
      trigger_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      check("busy edge ignored", 0, busy_o);
      wb(0, STATUS_ADDR, 32'h0);
      check("plain trig invalid", 0, rd[STAT_VALID_BIT]);
   endtask : t_auto

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   initial begin
      #1_000_000;
      n_fail++;
      close_out();
   end

   initial begin
      {cyc_i, stb_i, we_i, trigger_i, over_range_i} = '0;
      adr_i = '0;
      dat_i = '0;
      sar_code_i = '0;
      n_fail = 0;
      n_compared = 0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_select();
      t_single();
      t_diff();
      t_free();
      t_auto();
      close_out();
   end

endmodule : tb

`default_nettype wire
